// ---- rag_defs.vh ----
// Constants for the RAM/ROM address generation block
// Summary of operation
// - Indirect RAM address joins three index registers
// - Direct mode uses second word as address
// - Memory-register ops reach sixteen fixed digits
// - Long branches replace all fourteen counter bits
// - Program memory split in 256-word pages
// - In-page jump replaces counter bits 7..0
// - Jump at page end lands next page
// - Zero-page call loads six bits, clears rest
// - Table jump uses immediate, acc, second acc
// - Table word bit 8 loads both accumulators
// - Table word bit 9 loads port latches
// - Both bits set update all four together
// - Table read leaves program flow sequential
// - Instruction words are ten bits wide
`ifndef RAG_DEFS_VH
`define RAG_DEFS_VH
`define RAG_PC_W        14
`define RAG_IW          10
`define RAG_RA_W        10
`define RAG_PAGE_W      8
`define RAG_ZP_W        6
`define RAG_MEMREG_BASE 10'h040
// Decoded operation codes presented by the instruction decoder
`define RAG_OP_NONE     4'h0
`define RAG_OP_INDIRECT 4'h1
`define RAG_OP_DIRECT   4'h2
`define RAG_OP_MEMREG   4'h3
`define RAG_OP_LONG     4'h4
`define RAG_OP_PAGE     4'h5
`define RAG_OP_ZPAGE    4'h6
`define RAG_OP_TABJMP   4'h7
`define RAG_OP_TABRD    4'h8
`define RAG_TB_ACC_BIT  8
`define RAG_TB_PORT_BIT 9
`endif

// ---- rag_pc_next.v ----
// Next program counter computation for all branch kinds
`timescale 1ns/100ps
`include "rag_defs.vh"
module rag_pc_next
#(
    parameter PC_W = 14
)
(
    input  wire [3:0]      op,       // Decoded operation
    input  wire [PC_W-1:0] pc_inc,   // Already incremented counter
    input  wire [PC_W-1:0] long_imm, // Long branch target
    input  wire [7:0]      page_imm, // In-page target
    input  wire [5:0]      zp_imm,   // Zero-page target
    input  wire [3:0]      tab_imm,  // Table jump immediate
    input  wire [3:0]      acc,      // Accumulator
    input  wire [3:0]      acc2,     // Second accumulator
    output reg  [PC_W-1:0] pc_nxt    // Next counter value
);
    always @*
    begin
        case (op)
            `RAG_OP_LONG:   pc_nxt = long_imm;
            `RAG_OP_PAGE:   pc_nxt = {pc_inc[PC_W-1:8], page_imm};
            `RAG_OP_ZPAGE:  pc_nxt = {{(PC_W-6){1'b0}}, zp_imm};
            `RAG_OP_TABJMP: pc_nxt = {{(PC_W-12){1'b0}}, tab_imm, acc2, acc};
            default:        pc_nxt = pc_inc;
        endcase
    end
endmodule

// ---- rag_ram_addr.v ----
// Data RAM address selection for the three addressing modes
`timescale 1ns/100ps
`include "rag_defs.vh"
module rag_ram_addr
(
    input  wire [3:0]  op,        // Decoded operation
    input  wire [1:0]  idx_hi,    // Index register high part
    input  wire [3:0]  idx_mid,   // Index register middle part
    input  wire [3:0]  idx_lo,    // Index register low part
    input  wire [9:0]  dir_word,  // Second instruction word
    input  wire [3:0]  mr_digit,  // Memory-register digit number
    output reg  [9:0]  ram_addr   // Selected address
);
    always @*
    begin
        case (op)
            `RAG_OP_DIRECT: ram_addr = dir_word;
            `RAG_OP_MEMREG: ram_addr = `RAG_MEMREG_BASE | {6'h00, mr_digit};
            default:        ram_addr = {idx_hi, idx_mid, idx_lo};
        endcase
    end
endmodule

// ---- rag_core.v ----
// RAM/ROM address generation: program counter, RAM address, table read
`timescale 1ns/100ps
`include "rag_defs.vh"
module rag_core
#(
    parameter PC_W = 14,
    parameter IW   = 10
)
(
    input  wire            clk,          // Core clock
    input  wire            nrst,         // Synchronous reset, active low
    input  wire            ce,           // Clock enable
    input  wire            fetch,        // One word fetched this cycle
    input  wire [IW-1:0]   rom_word,     // Word from program ROM
    input  wire [3:0]      op,           // Decoded operation, valid on fetch
    input  wire [PC_W-1:0] long_imm,     // Long branch immediate
    input  wire [7:0]      page_imm,     // In-page immediate
    input  wire [5:0]      zp_imm,       // Zero-page immediate
    input  wire [3:0]      tab_imm,      // Table jump immediate
    input  wire [3:0]      mr_digit,     // Memory-register digit number
    input  wire [1:0]      idx_hi,       // Index high
    input  wire [3:0]      idx_mid,      // Index middle
    input  wire [3:0]      idx_lo,       // Index low
    input  wire [3:0]      acc,          // Accumulator
    input  wire [3:0]      acc2,         // Second accumulator
    output reg  [PC_W-1:0] pc_r,         // Program counter
    output reg  [9:0]      ram_addr_r,   // Data RAM address
    output reg             ram_valid_r,  // RAM address valid
    output reg             tab_busy_r,   // Table word being read
    output reg  [PC_W-1:0] rom_addr_r,   // ROM address for table read
    output reg             acc_we_r,     // Load both accumulators
    output reg  [3:0]      acc_d_r,      // Accumulator data
    output reg  [3:0]      acc2_d_r,     // Second accumulator data
    output reg             port_we_r,    // Load port latches
    output reg  [3:0]      port_one_out_latch, // Port one latch
    output reg  [3:0]      port_two_out_latch  // Port two latch
);
    localparam ST_OP   = 2'd0;
    localparam ST_DIR  = 2'd1;
    localparam ST_TAB  = 2'd2;

    reg  [1:0]      state_r;
    reg  [1:0]      state_nxt;
    wire [PC_W-1:0] pc_inc;
    wire [PC_W-1:0] pc_nxt;
    wire [9:0]      ram_addr_nxt;
    wire [3:0]      eff_op;

    assign pc_inc = pc_r + {{(PC_W-1){1'b0}}, 1'b1};
    // Branch ops only act on a fresh opcode word
    assign eff_op = (state_r == ST_OP) ? op : `RAG_OP_NONE;

    rag_pc_next #(.PC_W(PC_W)) u_pc
    (
        .op       (eff_op),
        .pc_inc   (pc_inc),
        .long_imm (long_imm),
        .page_imm (page_imm),
        .zp_imm   (zp_imm),
        .tab_imm  (tab_imm),
        .acc      (acc),
        .acc2     (acc2),
        .pc_nxt   (pc_nxt)
    );

    rag_ram_addr u_ra
    (
        .op       ((state_r == ST_DIR) ? `RAG_OP_DIRECT : op),
        .idx_hi   (idx_hi),
        .idx_mid  (idx_mid),
        .idx_lo   (idx_lo),
        .dir_word (rom_word[9:0]),
        .mr_digit (mr_digit),
        .ram_addr (ram_addr_nxt)
    );

    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_OP:
            begin
                if (fetch && op == `RAG_OP_DIRECT)
                    state_nxt = ST_DIR;
                else if (fetch && op == `RAG_OP_TABRD)
                    state_nxt = ST_TAB;
            end
            ST_DIR:
            begin
                if (fetch)
                    state_nxt = ST_OP;
            end
            ST_TAB:
                state_nxt = ST_OP;
            default:
                state_nxt = ST_OP;
        endcase
    end

    always @(posedge clk)
    begin
        if (!nrst)
        begin
            state_r            <= ST_OP;
            pc_r               <= {PC_W{1'b0}};
            ram_addr_r         <= 10'h000;
            ram_valid_r        <= 1'b0;
            tab_busy_r         <= 1'b0;
            rom_addr_r         <= {PC_W{1'b0}};
            acc_we_r           <= 1'b0;
            acc_d_r            <= 4'h0;
            acc2_d_r           <= 4'h0;
            port_we_r          <= 1'b0;
            port_one_out_latch <= 4'h0;
            port_two_out_latch <= 4'h0;
        end
        else if (ce)
        begin
            state_r     <= state_nxt;
            acc_we_r    <= 1'b0;
            port_we_r   <= 1'b0;
            ram_valid_r <= 1'b0;
            tab_busy_r  <= (state_nxt == ST_TAB);
            // each fetched word outside the table cycle, second words included
            if (fetch && state_r != ST_TAB)
                pc_r <= pc_nxt;
            if (fetch && state_r == ST_OP &&
                (op == `RAG_OP_INDIRECT || op == `RAG_OP_MEMREG))
            begin
                ram_addr_r  <= ram_addr_nxt;
                ram_valid_r <= 1'b1;
            end
            if (fetch && state_r == ST_DIR)
            begin
                ram_addr_r  <= ram_addr_nxt;
                ram_valid_r <= 1'b1;
            end
            if (fetch && state_r == ST_OP && op == `RAG_OP_TABRD)
                rom_addr_r <= {{(PC_W-12){1'b0}}, tab_imm, acc2, acc};
            // The table word arrives on rom_word in the cycle after the opcode
            if (state_r == ST_TAB)
            begin
                if (rom_word[`RAG_TB_ACC_BIT])
                begin
                    acc_we_r <= 1'b1;
                    acc_d_r  <= rom_word[3:0];
                    acc2_d_r <= rom_word[7:4];
                end
                if (rom_word[`RAG_TB_PORT_BIT])
                begin
                    port_we_r          <= 1'b1;
                    port_one_out_latch <= rom_word[3:0];
                    port_two_out_latch <= rom_word[7:4];
                end
            end
        end
    end
endmodule

// ---- rag_core_monitor.sv ----
// Assertion checker of the address generation core
`timescale 1ns/100ps
`include "rag_defs.vh"
module rag_core_monitor
(
    input wire        clk,        // Clock
    input wire        nrst,       // Reset
    input wire        ce,         // Enable
    input wire        fetch,      // Fetch
    input wire [9:0]  rom_word,   // Word
    input wire [3:0]  op,         // Op
    input wire [13:0] long_imm,   // Target
    input wire [7:0]  page_imm,   // Target
    input wire [5:0]  zp_imm,     // Target
    input wire [3:0]  tab_imm,    // Table
    input wire [1:0]  idx_hi,     // Index
    input wire [3:0]  idx_mid,    // Index
    input wire [3:0]  idx_lo,     // Index
    input wire [3:0]  acc,        // Acc
    input wire [3:0]  acc2,       // Acc two
    input wire [13:0] pc_r,       // Counter
    input wire [9:0]  ram_addr_r, // Address
    input wire        tab_busy_r, // Table
    input wire        acc_we_r,   // Load
    input wire        port_we_r   // Load
);
    // A table cycle ignores fetch, so it never counts as a taken word
    wire        go = ce && fetch && !tab_busy_r;
    wire [13:0] pc_inc = pc_r + 14'h0001;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_dir;
        go && op == `RAG_OP_DIRECT ##1 go;
    endsequence
    sequence s_tab;
        go && op == `RAG_OP_TABRD ##1 tab_busy_r && ce;
    endsequence
    chk_long_jump: assert property (go && op == `RAG_OP_LONG |=> pc_r == $past(long_imm))
        else $error("long jump target wrong");
    chk_page_jump: assert property (go && op == `RAG_OP_PAGE |=>
        pc_r == {$past(pc_inc[13:8]), $past(page_imm)}) else $error("page jump wrong");
    chk_zero_page: assert property (go && op == `RAG_OP_ZPAGE |=>
        pc_r == {8'h00, $past(zp_imm)}) else $error("zero page call wrong");
    chk_table_jump: assert property (go && op == `RAG_OP_TABJMP |=>
        pc_r == {2'h0, $past(tab_imm), $past(acc2), $past(acc)}) else $error("table jump wrong");
    chk_seq_step: assert property (go && op == `RAG_OP_NONE |=> pc_r == $past(pc_inc))
        else $error("counter step wrong");
    chk_index_addr: assert property (go && op == `RAG_OP_INDIRECT |=>
        ram_addr_r == {$past(idx_hi), $past(idx_mid), $past(idx_lo)}) else $error("indirect wrong");
    chk_direct_addr: assert property (s_dir |=> ram_addr_r == $past(rom_word))
        else $error("direct address wrong");
    chk_table_read: assert property (s_tab |=> acc_we_r == $past(rom_word[8]) &&
        port_we_r == $past(rom_word[9]) && pc_r == $past(pc_r)) else $error("table read wrong");
    chk_ce_freeze: assert property (!ce |=>
        pc_r == $past(pc_r) && ram_addr_r == $past(ram_addr_r)) else $error("moved while disabled");
endmodule
bind rag_core rag_core_monitor rag_core_monitor_inst (.*);

// ---- rag_rom_model.sv ----
// Program ROM model answering opcode and table fetches
`timescale 1ns/100ps
module rag_rom_model
(
    input wire [13:0] pc_r,       // Fetch address
    input wire [13:0] rom_addr_r, // Table address
    input wire        tab_busy_r, // Table cycle
    output wire [9:0] rom_word    // Word read
);
    wire [13:0] a = tab_busy_r ? rom_addr_r : pc_r;
    assign rom_word = {a[1:0], a[9:2]};
endmodule

// ---- rag_tb.sv ----
// Self-checking bench of the address generation core
`timescale 1ns/100ps
`include "rag_defs.vh"
module testbench;
    reg         clk = 1'b0, nrst = 1'b0, ce = 1'b1, fetch = 1'b0;
    reg  [3:0]  op = 4'h0, tab_imm = 4'h0, mr_digit = 4'h0, idx_mid = 4'h0, idx_lo = 4'h0;
    reg  [3:0]  acc = 4'h0, acc2 = 4'h0;
    reg  [1:0]  idx_hi = 2'h0;
    reg  [13:0] long_imm = 14'h0000, p;
    reg  [7:0]  page_imm = 8'h00, lat = 8'h00;
    reg  [5:0]  zp_imm = 6'h00;
    reg  [9:0]  w;
    wire [13:0] pc_r, rom_addr_r;
    wire [9:0]  rom_word, ram_addr_r;
    wire [3:0]  acc_d_r, acc2_d_r, port_one_out_latch, port_two_out_latch;
    wire        ram_valid_r, tab_busy_r, acc_we_r, port_we_r;
    integer     failures = 0, cmp_count = 0, cyc_n = 0, k;
    rag_core rag_core_inst (.clk, .nrst, .ce, .fetch, .rom_word, .op, .long_imm, .page_imm,
        .zp_imm, .tab_imm, .mr_digit, .idx_hi, .idx_mid, .idx_lo, .acc, .acc2, .pc_r,
        .ram_addr_r, .ram_valid_r, .tab_busy_r, .rom_addr_r, .acc_we_r, .acc_d_r, .acc2_d_r,
        .port_we_r, .port_one_out_latch, .port_two_out_latch);
    rag_rom_model rag_rom_model_inst (.pc_r, .rom_addr_r, .tab_busy_r, .rom_word);
    initial forever #4 clk = ~clk;
    function [9:0] rom_f(input [13:0] a);
        rom_f = {a[1:0], a[9:2]};
    endfunction
    task chk(input [13:0] seen, input [13:0] exp, input string nm);
        cmp_count = cmp_count + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task end_of_test;
        $display("Checks %0d, failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // One word per edge; the #1 lets the edge's updates land before any check
    task go(input [3:0] o, input f);
        @(posedge clk);
        op <= o;
        fetch <= f;
        #1;
    endtask
    task t_branch;
        long_imm <= 14'h12FF;
        page_imm <= 8'h34;
        zp_imm <= 6'h2A;
        tab_imm <= 4'hC;
        acc2 <= 4'h5;
        acc <= 4'h9;
        go(`RAG_OP_LONG, 1'b1);
        go(`RAG_OP_PAGE, 1'b1);
        chk(pc_r, 14'h12FF, "long");
        go(`RAG_OP_NONE, 1'b1);
        chk(pc_r, 14'h1334, "page end");
        go(`RAG_OP_ZPAGE, 1'b1);
        chk(pc_r, 14'h1335, "step");
        go(`RAG_OP_TABJMP, 1'b1);
        chk(pc_r, 14'h002A, "zero page");
        go(`RAG_OP_NONE, 1'b0);
        chk(pc_r, 14'h0C59, "table jump");
    endtask
    task t_ram;
        {idx_hi, idx_mid, idx_lo} <= 10'h3A5;
        mr_digit <= 4'hF;
        go(`RAG_OP_INDIRECT, 1'b1);
        go(`RAG_OP_MEMREG, 1'b1);
        chk(ram_addr_r, 14'h03A5, "indirect");
        chk(ram_valid_r, 1'b1, "indirect valid");
        go(`RAG_OP_DIRECT, 1'b1);
        chk(ram_addr_r, 14'h004F, "memreg");
        p = pc_r;
        go(`RAG_OP_NONE, 1'b1);
        chk(ram_valid_r, 1'b0, "no early valid");
        go(`RAG_OP_NONE, 1'b0);
        chk(ram_addr_r, rom_f(p + 14'h0001), "direct");
        chk(ram_valid_r, 1'b1, "direct valid");
        chk(pc_r, p + 14'h0002, "two words");
    endtask
    task t_table;
        for (k = 0; k < 4; k = k + 1)
        begin
            acc <= 4'hC | k[3:0];
            acc2 <= 4'h6;
            tab_imm <= k[3:0];
            go(`RAG_OP_TABRD, 1'b1);
            p = pc_r;
            w = rom_f({2'h0, k[3:0], 4'h6, 4'hC | k[3:0]});
            go(`RAG_OP_NONE, 1'b0);
            chk(tab_busy_r, 1'b1, "table busy");
            chk(rom_addr_r, {2'h0, k[3:0], 4'h6, 4'hC | k[3:0]}, "table addr");
            go(`RAG_OP_NONE, 1'b0);
            lat = w[9] ? w[7:0] : lat;
            chk(acc_we_r, w[8], "acc load");
            chk(port_we_r, w[9], "port load");
            chk({port_two_out_latch, port_one_out_latch}, lat, "latches");
            if (w[8])
                chk({acc2_d_r, acc_d_r}, w[7:0], "acc data");
            chk(pc_r, p + 14'h0001, "no branch");
        end
    endtask
    // Clock enable low must hold a taken long jump, then a mid-run reset clears the counter and port latches
    task t_freeze;
        p = pc_r;
        long_imm <= 14'h2ABC;
        ce <= 1'b0;
        go(`RAG_OP_LONG, 1'b1);
        go(`RAG_OP_LONG, 1'b1);
        chk(pc_r, p, "frozen");
        ce <= 1'b1;
        go(`RAG_OP_NONE, 1'b0);
        chk(pc_r, 14'h2ABC, "resumed");
        nrst <= 1'b0;
        go(`RAG_OP_NONE, 1'b0);
        chk(pc_r, 14'h0000, "mid reset");
        chk({port_two_out_latch, port_one_out_latch}, 8'h00, "latch reset");
        nrst <= 1'b1;
        go(`RAG_OP_PAGE, 1'b1);
        go(`RAG_OP_NONE, 1'b0);
        chk(pc_r, 14'h0034, "page after reset");
    endtask
    always @(posedge clk)
    begin
        cyc_n = cyc_n + 1;
        if (cyc_n == 200)
        begin
            failures = failures + 1;
            end_of_test;
        end
    end
    initial
    begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk(pc_r, 14'h0000, "reset");
        t_branch;
        t_ram;
        t_table;
        t_freeze;
        end_of_test;
    end
endmodule
